// ==== src/pbl_params.svh ====
/*
 Register offsets, field positions and reset values of the port B lower pin logic.
 Assumes an Avalon-MM slave with 32-bit words and byte addresses.
*/
`ifndef PBL_PARAMS_SVH
`define PBL_PARAMS_SVH
`define PBL_OFF_DATA 4'h0
`define PBL_OFF_DIR 4'h4
`define PBL_OFF_PDI 4'h8
`define PBL_OFF_CTRL 4'hC
`define PBL_DIR_RESET 8'h00
`define PBL_PDI_RESET 8'h00
`define PBL_CTRL_RESET 8'h00
`define PBL_CTRL_GPD 0
`define PBL_CTRL_TIMER_COMPARE_LEVEL 1
`define PBL_CTRL_CSEL 2
`define PBL_CTRL_COE 3
`define PBL_PIN_FOUR 4
`define PBL_PDI_READ 32'h0000_0000
`define PBL_UNMAPPED_READ 32'h0000_0000
`endif

// ==== src/pbl_pkg.sv ====
/*
 Types shared by the port B lower pin logic.
 Assumes the header pbl_params.svh for numeric constants.
*/
package pbl_pkg;
    typedef enum logic [2:0] {
        PBL_IDLE = 3'b001,
        PBL_WAIT = 3'b010,
        PBL_DONE = 3'b100
    } pbl_bus_state_t;
endpackage

// ==== src/pbl_pin_if.sv ====
/*
 Per-pin control bundle between the register core and the pad slice.
 Assumes one clock domain on both sides.
*/
`timescale 1ns/1ns
interface pbl_pin_if #(parameter int WIDTH = 8);
    logic [WIDTH-1:0] dir;
    logic [WIDTH-1:0] latch;
    logic [WIDTH-1:0] pdi;
    logic gpd;
    logic pin4_extra;
    logic [WIDTH-1:0] pin_in;
    logic [WIDTH-1:0] pad_out;
    logic [WIDTH-1:0] pad_oe;
    logic [WIDTH-1:0] pad_pd;
    logic [WIDTH-1:0] rd_val;
    modport core (output dir, latch, pdi, gpd, pin4_extra, pin_in,
                  input pad_out, pad_oe, pad_pd, rd_val);
    modport pad (input dir, latch, pdi, gpd, pin4_extra, pin_in,
                 output pad_out, pad_oe, pad_pd, rd_val);
endinterface

// ==== src/pbl_pad_slice.sv ====
/*
 Combinational pad logic: drive value, buffer enable, pulldown and read mux per pin.
 Assumes synchronised pin levels and registered controls from the core.
*/
`timescale 1ns/1ns
`include "pbl_params.svh"
module pbl_pad_slice #(parameter int WIDTH = 8) (
    pbl_pin_if.pad p
);
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_pin
            wire logic drive_val;
            if (i == `PBL_PIN_FOUR) begin : g_four
                assign drive_val = p.latch[i] | p.pin4_extra;
            end else begin : g_plain
                assign drive_val = p.latch[i];
            end
            assign p.pad_out[i] = drive_val;
            assign p.pad_oe[i] = p.dir[i];
            assign p.pad_pd[i] = ~p.dir[i] & ~p.pdi[i] & ~p.gpd;
            assign p.rd_val[i] = p.dir[i] ? drive_val : p.pin_in[i];
        end
    endgenerate
endmodule

// ==== src/pbl_port.sv ====
/*
 Port B lower pin logic: registers over Avalon-MM, pad controls and shared-module taps.
 Assumes an Avalon-MM master honouring waitrequest and external pad cells.
*/
`timescale 1ns/1ns
`include "pbl_params.svh"
module pbl_port #(parameter int WIDTH = 8) (
    input wire logic SYS_CLK,
    input wire logic RESET,
    input wire logic [3:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    input wire logic [WIDTH-1:0] PIN_IN,
    output logic [WIDTH-1:0] PIN_OUT,
    output logic [WIDTH-1:0] PIN_OE,
    output logic [WIDTH-1:0] PIN_PULLDOWN,
    input wire logic COMPARATOR_ONE_OUTPUT,
    output logic [3:0] SHARED_INPUT,
    output logic ANALOG_CHANNEL_FOUR
);
    pbl_pin_if #(.WIDTH(WIDTH)) pif ();
    pbl_pkg::pbl_bus_state_t state_r;
    pbl_pkg::pbl_bus_state_t state_nxt;
    logic [WIDTH-1:0] sync1_r;
    logic [WIDTH-1:0] sync2_r;
    logic [WIDTH-1:0] sync3_r;
    logic [WIDTH-1:0] pin_r;
    logic [WIDTH-1:0] direction_bits_r;
    logic [WIDTH-1:0] pulldown_inhibit_bits_r;
    logic [WIDTH-1:0] port_data_latch_r;
    logic [7:0] ctrl_r;
    logic cmp_s1_r;
    logic cmp_s2_r;
    logic cmp_s3_r;
    logic cmp_r;
    logic [31:0] rdata_nxt;

    wire logic req = AVS_READ | AVS_WRITE;
    wire logic take = (state_r == pbl_pkg::PBL_WAIT);
    // Write lands at the edge where the master sees waitrequest low
    wire logic accept = (state_r == pbl_pkg::PBL_DONE);
    wire logic wr_en = accept & AVS_WRITE & AVS_BYTEENABLE[0];
    wire logic hit_data = (AVS_ADDRESS == `PBL_OFF_DATA);
    wire logic hit_dir = (AVS_ADDRESS == `PBL_OFF_DIR);
    wire logic hit_pdi = (AVS_ADDRESS == `PBL_OFF_PDI);
    wire logic hit_ctrl = (AVS_ADDRESS == `PBL_OFF_CTRL);
    wire logic global_pulldown_disable = ctrl_r[`PBL_CTRL_GPD];
    wire logic timer_compare_level = ctrl_r[`PBL_CTRL_TIMER_COMPARE_LEVEL];
    wire logic comparator_pin_select = ctrl_r[`PBL_CTRL_CSEL];
    wire logic comparator_output_enable = ctrl_r[`PBL_CTRL_COE];
    wire logic cmp_gated = cmp_r & comparator_pin_select & comparator_output_enable;

    assign pif.dir = direction_bits_r;
    assign pif.latch = port_data_latch_r;
    assign pif.pdi = pulldown_inhibit_bits_r;
    assign pif.gpd = global_pulldown_disable;
    assign pif.pin4_extra = timer_compare_level | cmp_gated;
    assign pif.pin_in = pin_r;

    pbl_pad_slice #(.WIDTH(WIDTH)) u_pad (
        .p(pif.pad)
    );

    // Read data selection
    always_comb begin
        rdata_nxt = `PBL_UNMAPPED_READ;
        if (hit_data) begin
            rdata_nxt = {{(32-WIDTH){1'b0}}, pif.rd_val};
        end else if (hit_dir) begin
            rdata_nxt = {{(32-WIDTH){1'b0}}, direction_bits_r};
        end else if (hit_pdi) begin
            rdata_nxt = `PBL_PDI_READ;
        end else if (hit_ctrl) begin
            rdata_nxt = {24'h00_0000, ctrl_r};
        end
    end

    // Bus handshake states
    always_comb begin
        case (state_r)
            pbl_pkg::PBL_IDLE: state_nxt = req ? pbl_pkg::PBL_WAIT : pbl_pkg::PBL_IDLE;
            pbl_pkg::PBL_WAIT: state_nxt = pbl_pkg::PBL_DONE;
            pbl_pkg::PBL_DONE: state_nxt = pbl_pkg::PBL_IDLE;
            default: state_nxt = pbl_pkg::PBL_IDLE;
        endcase
    end

    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            state_r <= pbl_pkg::PBL_IDLE;
            AVS_WAITREQUEST <= 1'b1;
            AVS_READDATA <= 32'h0000_0000;
        end else begin
            state_r <= state_nxt;
            AVS_WAITREQUEST <= ~take;
            if (take & AVS_READ) begin
                AVS_READDATA <= rdata_nxt;
            end
        end
    end

    // Pin input synchronisers
    always_ff @(posedge SYS_CLK) begin
        sync1_r <= PIN_IN;
        sync2_r <= sync1_r;
        sync3_r <= sync2_r;
        cmp_s1_r <= COMPARATOR_ONE_OUTPUT;
        cmp_s2_r <= cmp_s1_r;
        cmp_s3_r <= cmp_s2_r;
    end

    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            pin_r <= {WIDTH{1'b0}};
            cmp_r <= 1'b0;
        end else begin
            pin_r <= (sync2_r & sync3_r) | (pin_r & (sync2_r | sync3_r));
            if (cmp_s2_r == cmp_s3_r) begin
                cmp_r <= cmp_s2_r;
            end
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            direction_bits_r <= `PBL_DIR_RESET;
            pulldown_inhibit_bits_r <= `PBL_PDI_RESET;
            ctrl_r <= `PBL_CTRL_RESET;
        end else begin
            if (wr_en & hit_dir) begin
                direction_bits_r <= AVS_WRITEDATA[WIDTH-1:0];
            end
            if (wr_en & hit_pdi) begin
                pulldown_inhibit_bits_r <= AVS_WRITEDATA[WIDTH-1:0];
            end
            if (wr_en & hit_ctrl) begin
                ctrl_r <= AVS_WRITEDATA[7:0];
            end
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (wr_en & hit_data) begin
            port_data_latch_r <= AVS_WRITEDATA[WIDTH-1:0];
        end
    end

    // Pad outputs registered
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            PIN_OUT <= {WIDTH{1'b0}};
            PIN_OE <= {WIDTH{1'b0}};
            PIN_PULLDOWN <= {WIDTH{1'b0}};
            SHARED_INPUT <= 4'h0;
            ANALOG_CHANNEL_FOUR <= 1'b0;
        end else begin
            PIN_OUT <= pif.pad_out;
            PIN_OE <= pif.pad_oe;
            PIN_PULLDOWN <= pif.pad_pd;
            SHARED_INPUT <= pin_r[3:0];
            ANALOG_CHANNEL_FOUR <= pin_r[`PBL_PIN_FOUR];
        end
    end
endmodule

// ==== testbench/pbl_port_monitor.sv ====
/*
 Checker of the pbl_port bus handshake, pad controls and pin taps.
 Assumes a bind onto pbl_port and a synchronous active-high reset.
*/
`timescale 1ns/1ns
module pbl_port_monitor #(parameter int WIDTH = 8) (
    input wire logic SYS_CLK,
    input wire logic RESET,
    input wire logic [3:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic [31:0] AVS_READDATA,
    input wire logic AVS_WAITREQUEST,
    input wire logic [WIDTH-1:0] PIN_IN,
    input wire logic [WIDTH-1:0] PIN_OE,
    input wire logic [WIDTH-1:0] PIN_PULLDOWN,
    input wire logic [3:0] SHARED_INPUT
);
    default clocking mon_cb @(posedge SYS_CLK);
    endclocking
    default disable iff (RESET);
    wire ack = AVS_READ && !AVS_WAITREQUEST;
    pd_drive_a: assert property ((PIN_OE & PIN_PULLDOWN) == '0)
        else $error("pulldown on a driven pin");
    reset_idle_a: assert property (disable iff (1'b0) RESET [*3] |-> PIN_OE == '0)
        else $error("pin driven in reset");
    wait_pulse_a: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
        else $error("waitrequest low twice");
    read_upper_a: assert property (ack |-> AVS_READDATA[31:8] == 24'h00_0000)
        else $error("upper read bits set");
    pdi_read_a: assert property (ack && AVS_ADDRESS == 4'h8 |-> AVS_READDATA[7:0] == 8'h00)
        else $error("inhibit read not zero");
    dir_read_a: assert property (ack && AVS_ADDRESS == 4'h4 |-> AVS_READDATA == 32'(PIN_OE))
        else $error("direction read differs");
    read_hold_a: assert property (!AVS_READ |=> $stable(AVS_READDATA))
        else $error("read data changed");
    shared_tap_a: assert property ($stable(PIN_IN) [*8] |-> SHARED_INPUT == PIN_IN[3:0])
        else $error("shared input differs");
    cover property (ack && AVS_ADDRESS == 4'h0);
    cover property (PIN_OE[4] && !AVS_WAITREQUEST);
    cover property (PIN_PULLDOWN[0] && PIN_OE[1]);
endmodule
bind pbl_port pbl_port_monitor #(.WIDTH(WIDTH)) pbl_port_monitor_i (.*);

// ==== testbench/tb_pbl_port.sv ====
/*
 Self-checking bench for pbl_port over Avalon-MM and the pins.
 Assumes the design sources and the monitor bind are compiled first.
*/
`timescale 1ns/1ns
module tb_pbl_port;
    logic SYS_CLK = 1'b0, RESET = 1'b1, AVS_READ = 1'b0, AVS_WRITE = 1'b0;
    logic COMPARATOR_ONE_OUTPUT = 1'b0, AVS_WAITREQUEST, ANALOG_CHANNEL_FOUR;
    logic [3:0] AVS_ADDRESS = 4'h0, AVS_BYTEENABLE = 4'h0, SHARED_INPUT;
    logic [31:0] AVS_WRITEDATA = 32'h0000_0000, AVS_READDATA;
    logic [7:0] PIN_IN = 8'h00, PIN_OUT, PIN_OE, PIN_PULLDOWN, d, p, l;
    logic [7:0] exp_q[$];
    integer n_fail = 0, checked = 0, seed = 42, i, k;
    always #5 SYS_CLK = ~SYS_CLK;
    pbl_port pbl_port_i (.*);
    task final_report;
        if (n_fail == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task cmp(input string n, input logic [7:0] e, input logic [7:0] s);
        checked = checked + 1;
        if (s !== e) begin
            n_fail = n_fail + 1;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask
    task bus(input logic w, input logic [3:0] a, input logic [7:0] v, input logic [3:0] be);
        AVS_ADDRESS <= a;
        AVS_WRITEDATA <= 32'(v);
        AVS_BYTEENABLE <= be;
        AVS_WRITE <= w;
        AVS_READ <= !w;
        @(posedge SYS_CLK);
        for (k = 1; k < 99 && AVS_WAITREQUEST !== 1'b0; k++)
            @(posedge SYS_CLK);
        if (k == 99) begin
            cmp("waitrequest", 8'h00, 8'h01);
            final_report;
        end
        AVS_READ <= 1'b0;
        AVS_WRITE <= 1'b0;
        @(posedge SYS_CLK);
    endtask
    task rd(input logic [3:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 8'h00, 4'hF);
    endtask
    always @(posedge SYS_CLK)
        if (AVS_READ && AVS_WAITREQUEST === 1'b0)
            cmp("readdata", exp_q.pop_front(), AVS_READDATA[7:0]);
    initial begin
        repeat (10) @(posedge SYS_CLK);
        RESET <= 1'b0;
        repeat (3) @(posedge SYS_CLK);
        cmp("oe", 8'h00, PIN_OE);
        cmp("pd", 8'hFF, PIN_PULLDOWN);
        for (i = 0; i < 6; i++) begin
            d = 8'($random(seed));
            p = 8'($random(seed));
            l = 8'($random(seed));
            PIN_IN <= 8'($random(seed));
            bus(1'b1, 4'h4, d, 4'h1);
            bus(1'b1, 4'h8, p, 4'h1);
            bus(1'b1, 4'hC, {7'h00, i[0]}, 4'h1);
            bus(1'b1, 4'h0, l, 4'h1);
            bus(1'b1, 4'h4, 8'hFF, 4'h0);
            rd(4'h4, d);
            rd(4'h8, 8'h00);
            rd(4'h2, 8'h00);
            rd(4'h0, (d & l) | (~d & PIN_IN));
            cmp("oe", d, PIN_OE);
            cmp("pd", ~d & ~p & {8{~i[0]}}, PIN_PULLDOWN);
            cmp("taps", PIN_IN[4:0], {ANALOG_CHANNEL_FOUR, SHARED_INPUT});
        end
        bus(1'b1, 4'h4, 8'hFF, 4'h1);
        rd(4'h0, l);
        cmp("out", l, PIN_OUT);
        bus(1'b1, 4'h0, 8'h00, 4'h1);
        for (i = 0; i < 32; i++) begin
            COMPARATOR_ONE_OUTPUT <= i[4];
            bus(1'b1, 4'hC, {4'h0, i[3:0]}, 4'h1);
            repeat (6) @(posedge SYS_CLK);
            cmp("out", {3'h0, i[1] | (i[2] & i[3] & i[4]), 4'h0}, PIN_OUT);
        end
        bus(1'b1, 4'h0, 8'h5A, 4'h1);
        RESET <= 1'b1;
        repeat (10) @(posedge SYS_CLK);
        RESET <= 1'b0;
        @(posedge SYS_CLK);
        rd(4'h4, 8'h00);
        bus(1'b1, 4'h4, 8'hFF, 4'h1);
        rd(4'h0, 8'h5A);
        final_report;
    end
endmodule
